// File: rtl/bst_device.sv
// Test access port and 20-bit signature/pattern self test of the boundary chain
// Functional notes
// - Input cells fold pins into 20-bit signature
// - Output cells step random pattern, drive falling
// - All-zero pattern seed stays locked at zero
// - Controller loads a seed before running
// - Count mode increments output cells, drives falling
// - Serial, select and pins sampled on rising
// - Serial and pin outputs change on falling
// - Controller moves mode-select on falling edge
// - Capture-IR loads instruction shifter with 10000001
// - Shift entry enables serial out on falling
// - Exit1 returns serial out to idle
// - Update-IR loads active instruction on falling
// - Bypass bit captures zero in Capture-DR
// - All-ones instruction decodes as bypass
// - Last bit shifts leaving Shift-IR
// - Mode-select low leaves Test-Logic-Reset
// - Control codes 011 and 111 pick operation
// - Runs only under run instruction in idle
// - Runs only when direction enables differ
`timescale 1ns/10ps
`default_nettype none
module bst_device #(
  parameter logic [19:0] TAPS = bst_pkg::LFSR_TAPS  // Feedback polynomial
) (
  bst_link_if.dev link,
  input wire logic rstn,
  input wire logic [bst_pkg::HALF_W-1:0] inPins,
  input wire logic aToBOutputEnableN,  // Active low, data flows A to B
  input wire logic bToAOutputEnableN,  // Active low, data flows B to A
  output logic [bst_pkg::HALF_W-1:0] outPins,
  output logic testActive
);
  import bst_pkg::*;

  // Rising-edge state
  bst_tap_t state_ff, nxt_state;  // Controller state
  logic [IR_W-1:0] irShift_ff, nxt_irShift;  // Instruction shifter
  logic bypass_ff, nxt_bypass;  // One-bit bypass register
  logic [CHAIN_W-1:0] chain_ff, nxt_chain;  // Shift stages of all cells
  logic [CTRL_W-1:0] ctrlReg_ff, nxt_ctrlReg;  // Operation select
  logic [HALF_W-1:0] pinMeta_ff, pinSync_ff;  // Pin synchroniser
  logic [1:0] oeMeta_ff, oeSync_ff;  // Direction enable synchroniser

  // Falling-edge state
  logic [IR_W-1:0] irActive_ff, nxt_irActive;  // Instruction in force
  logic tdo_ff, nxt_tdo;  // Serial out value
  logic tdoOe_ff, nxt_tdoOe;  // Serial out enable
  logic [HALF_W-1:0] shadow_ff, nxt_shadow;  // Output cell shadow latches
  logic active_ff, nxt_active;  // Operation running, seen at the pins

  // Decoded conditions
  logic selChain;  // Boundary chain in the scan path
  logic selCtrl;  // Control register in the scan path
  logic opValid;  // Control code is one of the two 20-bit operations
  logic runOn;  // Self test advances on this rising edge
  logic drLsb;  // Serial out bit of the selected data register

  // Instruction decode; anything not known behaves as bypass
  always_comb begin
    selChain = (irActive_ff == OP_CHAIN);
    selCtrl = (irActive_ff == OP_CTRL_SCAN);
    opValid = (ctrlReg_ff == CTRL_SIG_RANDOM) || (ctrlReg_ff == CTRL_SIG_COUNT);
    // Other codes (40-bit, toggle) are not supported here and run nothing
    runOn = (irActive_ff == OP_RUN_SELECTED_TEST) && (state_ff == TAP_IDLE)
            && (oeSync_ff[0] != oeSync_ff[1]) && opValid;
    if (selChain) begin
      drLsb = chain_ff[0];
    end else if (selCtrl) begin
      drLsb = ctrlReg_ff[0];
    end else begin
      drLsb = bypass_ff;
    end
  end

  // Controller next state, mode-select taken on the rising edge
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TAP_RESET: nxt_state = link.tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: nxt_state = link.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: nxt_state = link.tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: nxt_state = link.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: nxt_state = link.tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: nxt_state = link.tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: nxt_state = link.tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: nxt_state = link.tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: nxt_state = link.tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: nxt_state = link.tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: nxt_state = link.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: nxt_state = link.tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: nxt_state = link.tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: nxt_state = link.tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: nxt_state = link.tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: nxt_state = link.tms ? TAP_SEL_DR : TAP_IDLE;
      default: nxt_state = TAP_RESET;
    endcase
  end

  // Rising-edge data registers: capture, shift and self test
  always_comb begin
    nxt_irShift = irShift_ff;
    nxt_bypass = bypass_ff;
    nxt_chain = chain_ff;
    nxt_ctrlReg = ctrlReg_ff;
    case (state_ff)
      TAP_CAP_IR: nxt_irShift = IR_CAPTURE;
      TAP_SH_IR: nxt_irShift = {link.tdi, irShift_ff[IR_W-1:1]};
      TAP_CAP_DR: begin
        // Chain and control register keep their value so a signature can be read
        if (!selChain && !selCtrl) begin
          nxt_bypass = 1'b0;
        end
      end
      TAP_SH_DR: begin
        if (selChain) begin
          nxt_chain = {link.tdi, chain_ff[CHAIN_W-1:1]};
        end else if (selCtrl) begin
          nxt_ctrlReg = {link.tdi, ctrlReg_ff[CTRL_W-1:1]};
        end else begin
          nxt_bypass = link.tdi;
        end
      end
      TAP_IDLE: begin
        if (runOn) begin
          // Input half compresses sampled pins through the feedback taps
          nxt_chain[HALF_W-1:0] = bst_lfsr(chain_ff[HALF_W-1:0], TAPS, pinSync_ff);
          if (ctrlReg_ff == CTRL_SIG_COUNT) begin
            nxt_chain[CHAIN_W-1:HALF_W] = chain_ff[CHAIN_W-1:HALF_W] + 20'h00001;
          end else begin
            // No fold-in, so a zero seed maps to zero forever
            nxt_chain[CHAIN_W-1:HALF_W] = bst_lfsr(chain_ff[CHAIN_W-1:HALF_W], TAPS,
                                                   20'h00000);
          end
        end
      end
      TAP_RESET: nxt_ctrlReg = CTRL_RESET;
      default: nxt_ctrlReg = ctrlReg_ff;
    endcase
  end

  // Rising-edge registers; pins cross in through two flops
  always_ff @(posedge link.tck or negedge rstn) begin
    if (!rstn) begin
      state_ff <= TAP_RESET;
      irShift_ff <= IR_CAPTURE;
      bypass_ff <= 1'b0;
      chain_ff <= '0;
      ctrlReg_ff <= CTRL_RESET;
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
      oeMeta_ff <= 2'h3;
      oeSync_ff <= 2'h3;
    end else begin
      state_ff <= nxt_state;
      irShift_ff <= nxt_irShift;
      bypass_ff <= nxt_bypass;
      chain_ff <= nxt_chain;
      ctrlReg_ff <= nxt_ctrlReg;
      pinMeta_ff <= inPins;
      pinSync_ff <= pinMeta_ff;
      oeMeta_ff <= {bToAOutputEnableN, aToBOutputEnableN};
      oeSync_ff <= oeMeta_ff;
    end
  end

  // Falling-edge next values: serial out, instruction update, shadow latches
  always_comb begin
    nxt_irActive = irActive_ff;
    nxt_shadow = shadow_ff;
    nxt_tdo = tdo_ff;
    nxt_tdoOe = 1'b0;
    nxt_active = runOn;
    if (state_ff == TAP_SH_IR) begin
      nxt_tdo = irShift_ff[0];
      nxt_tdoOe = 1'b1;
    end else if (state_ff == TAP_SH_DR) begin
      nxt_tdo = drLsb;
      nxt_tdoOe = 1'b1;
    end
    if (state_ff == TAP_RESET) begin
      nxt_irActive = IR_RESET;
    end else if (state_ff == TAP_UPD_IR) begin
      nxt_irActive = irShift_ff;
    end
    // Shadow follows the output half after a preload or on each falling edge while runOn holds
    if (runOn || (state_ff == TAP_UPD_DR && selChain)) begin
      nxt_shadow = chain_ff[CHAIN_W-1:HALF_W];
    end
  end

  // Falling-edge registers keep outputs away from the sampling edge
  always_ff @(negedge link.tck or negedge rstn) begin
    if (!rstn) begin
      irActive_ff <= IR_RESET;
      tdo_ff <= 1'b0;
      tdoOe_ff <= 1'b0;
      shadow_ff <= '0;
      active_ff <= 1'b0;
    end else begin
      irActive_ff <= nxt_irActive;
      tdo_ff <= nxt_tdo;
      tdoOe_ff <= nxt_tdoOe;
      shadow_ff <= nxt_shadow;
      active_ff <= nxt_active;
    end
  end

  assign link.tdoOut = tdo_ff;
  assign link.tdoOe = tdoOe_ff;
  assign outPins = shadow_ff;
  assign testActive = active_ff;
endmodule : bst_device
`default_nettype wire

// File: rtl/bst_host.sv
// Host end: makes the test clock and plays reset, instruction, data and idle scans
`timescale 1ns/10ps
`default_nettype none
module bst_host #(
  parameter int DIV = bst_pkg::TCK_DIV  // Core cycles per test clock half period
) (
  input wire logic core_clk,
  input wire logic rstn,
  bst_link_if.host link,
  input wire logic cmdValid,
  input wire bst_pkg::bst_cmd_t cmdKind,
  input wire logic [bst_pkg::LEN_W-1:0] cmdLen,
  input wire logic [bst_pkg::CHAIN_W-1:0] cmdData,
  output logic cmdReady,
  output logic rspValid,
  output logic [bst_pkg::CHAIN_W-1:0] rspData
);
  import bst_pkg::*;

  typedef enum logic [1:0] {H_IDLE = 2'h0, H_RUN = 2'h1} bst_host_st_t;

  bst_host_st_t st_ff, nxt_st;  // Command state
  logic [7:0] div_ff, nxt_div;  // Clock divider count
  logic tck_ff, nxt_tck;  // Test clock out
  logic tms_ff, nxt_tms;  // Mode select out
  logic tdi_ff, nxt_tdi;  // Serial data out
  logic [SEQ_W-1:0] seq_ff, nxt_seq;  // Mode-select bits of the command
  logic [STEP_W-1:0] step_ff, nxt_step;  // Steps already played
  logic [STEP_W-1:0] total_ff, nxt_total;  // Steps in the command
  logic [STEP_W-1:0] pre_ff, nxt_pre;  // First shift step
  logic [STEP_W-1:0] len_ff, nxt_len;  // Shift steps
  logic armed_ff, nxt_armed;  // A step is presented, waiting for its rising edge
  logic [CHAIN_W-1:0] data_ff, nxt_data;  // Bits still to send
  logic [CHAIN_W-1:0] rsp_ff, nxt_rsp;  // Bits caught from serial out
  logic rspValid_ff, nxt_rspValid;
  logic cmdReady_ff, nxt_cmdReady;  // Idle flag, kept in a flop so the output is clean
  logic tdoMeta_ff, tdoSync_ff;  // Serial-out synchroniser
  logic tick, fall, rise, inShift;
  logic [STEP_W-1:0] bitIdx;

  // Mode-select pattern of one command, started from Run-Test/Idle
  function automatic logic [SEQ_W-1:0] build_seq(input bst_cmd_t kind,
                                                 input logic [STEP_W-1:0] pre,
                                                 input logic [STEP_W-1:0] len);
    logic [SEQ_W-1:0] s;
    s = '0;
    for (int i = 0; i < SEQ_W; i++) begin
      if (kind == CMD_RESET) begin
        s[i] = (i < 5);  // Five ones reach reset, then a zero leaves it
      end else if (kind != CMD_IDLE) begin
        if (i == 0) begin
          s[i] = 1'b1;  // Select-DR
        end else if (i == 1) begin
          s[i] = (kind == CMD_IR);  // Select-IR, or Capture-DR
        end else if (i + 1 == int'(pre + len) || i == int'(pre + len)) begin
          s[i] = 1'b1;  // Last shift bit leaves Shift, then Update
        end
      end
    end
    build_seq = s;
  endfunction : build_seq

  // Divider and command sequencing
  always_comb begin
    tick = (div_ff == 8'(DIV - 1));
    fall = tick && tck_ff;
    rise = tick && !tck_ff;
    bitIdx = step_ff - pre_ff;
    inShift = (step_ff >= pre_ff) && (bitIdx < len_ff);
    nxt_div = tick ? 8'h00 : div_ff + 8'h01;
    nxt_tck = tick ? !tck_ff : tck_ff;
    nxt_st = st_ff;
    nxt_tms = tms_ff;
    nxt_tdi = tdi_ff;
    nxt_seq = seq_ff;
    nxt_step = step_ff;
    nxt_total = total_ff;
    nxt_pre = pre_ff;
    nxt_len = len_ff;
    nxt_armed = armed_ff;
    nxt_data = data_ff;
    nxt_rsp = rsp_ff;
    nxt_rspValid = 1'b0;
    case (st_ff)
      H_IDLE: begin
        if (cmdValid) begin
          nxt_st = H_RUN;
          nxt_step = '0;
          nxt_armed = 1'b0;
          nxt_data = cmdData;
          nxt_rsp = '0;
          nxt_len = (cmdKind == CMD_IR || cmdKind == CMD_DR) ? STEP_W'(cmdLen) : '0;
          nxt_pre = (cmdKind == CMD_IR) ? STEP_W'(PRE_IR) :
                    (cmdKind == CMD_DR) ? STEP_W'(PRE_DR) : '0;
          case (cmdKind)
            CMD_RESET: nxt_total = STEP_W'(RESET_LEN);
            CMD_IDLE: nxt_total = STEP_W'(cmdLen);
            default: nxt_total = nxt_pre + STEP_W'(cmdLen) + 7'h02;
          endcase
          nxt_seq = build_seq(cmdKind, nxt_pre, nxt_len);
        end
      end
      H_RUN: begin
        if (fall) begin
          // Present the next step on the falling edge of the test clock
          if (step_ff == total_ff) begin
            nxt_st = H_IDLE;
            nxt_rspValid = 1'b1;
          end else begin
            nxt_tms = seq_ff[step_ff[5:0]];
            nxt_tdi = inShift ? data_ff[0] : tdi_ff;
            nxt_armed = 1'b1;
          end
        end else if (rise && armed_ff) begin
          nxt_armed = 1'b0;
          nxt_step = step_ff + 7'h01;
          if (inShift) begin
            nxt_data = {1'b0, data_ff[CHAIN_W-1:1]};
            nxt_rsp[bitIdx[5:0]] = tdoSync_ff;
          end
        end
      end
      default: nxt_st = H_IDLE;
    endcase
    // Ready follows the state the next edge will hold
    nxt_cmdReady = (nxt_st == H_IDLE);
  end

  // Registers; serial out crosses in through two flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= H_IDLE;
      div_ff <= 8'h00;
      tck_ff <= 1'b0;
      tms_ff <= 1'b1;
      tdi_ff <= 1'b0;
      seq_ff <= '0;
      step_ff <= '0;
      total_ff <= '0;
      pre_ff <= '0;
      len_ff <= '0;
      armed_ff <= 1'b0;
      data_ff <= '0;
      rsp_ff <= '0;
      rspValid_ff <= 1'b0;
      cmdReady_ff <= 1'b1;
      tdoMeta_ff <= 1'b1;
      tdoSync_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      div_ff <= nxt_div;
      tck_ff <= nxt_tck;
      tms_ff <= nxt_tms;
      tdi_ff <= nxt_tdi;
      seq_ff <= nxt_seq;
      step_ff <= nxt_step;
      total_ff <= nxt_total;
      pre_ff <= nxt_pre;
      len_ff <= nxt_len;
      armed_ff <= nxt_armed;
      data_ff <= nxt_data;
      rsp_ff <= nxt_rsp;
      rspValid_ff <= nxt_rspValid;
      cmdReady_ff <= nxt_cmdReady;
      tdoMeta_ff <= link.tdo;
      tdoSync_ff <= tdoMeta_ff;
    end
  end

  assign link.tck = tck_ff;
  assign link.tms = tms_ff;
  assign link.tdi = tdi_ff;
  assign cmdReady = cmdReady_ff;
  assign rspValid = rspValid_ff;
  assign rspData = rsp_ff;
endmodule : bst_host
`default_nettype wire

// File: rtl/bst_link_if.sv
// Four-wire test access link between the host controller and the device
`timescale 1ns/10ps
`default_nettype none
interface bst_link_if;
  logic tck;  // Test clock, made by the host
  logic tms;  // Mode select
  logic tdi;  // Serial data into the device
  logic tdoOut;  // Serial data driven by the device
  logic tdoOe;  // High while the device drives serial out
  logic tdo;  // Resolved line, pulled high when undriven
  assign tdo = tdoOe ? tdoOut : 1'b1;
  modport dev (input tck, input tms, input tdi, output tdoOut, output tdoOe);
  modport host (output tck, output tms, output tdi, input tdo);
endinterface : bst_link_if
`default_nettype wire

// File: rtl/bst_pkg.sv
// Shared constants, types and helpers for the boundary-scan signature test block
package bst_pkg;
  localparam int HALF_W = 20;  // Cells per half of the boundary chain
  localparam int CHAIN_W = 40;  // Input half low, output half high
  localparam int IR_W = 8;  // Instruction register width
  localparam int CTRL_W = 3;  // Boundary control register width
  localparam int LEN_W = 6;  // Width of a scan length field
  localparam int SEQ_W = 64;  // Longest mode-select sequence the host plays
  localparam int STEP_W = 7;  // Index into that sequence
  localparam int TCK_DIV = 4;  // Core cycles per half period of the test clock
  // Instruction codes
  localparam logic [7:0] IR_CAPTURE = 8'h81;  // Fixed value caught in Capture-IR
  localparam logic [7:0] OP_BYPASS = 8'hff;
  localparam logic [7:0] OP_RUN_SELECTED_TEST = 8'h09;  // Run the operation in the control reg
  localparam logic [7:0] OP_CHAIN = 8'h82;  // Boundary chain in the scan path, no capture
  localparam logic [7:0] OP_CTRL_SCAN = 8'h84;  // Control register in the scan path
  localparam logic [7:0] IR_RESET = 8'hff;  // Active instruction after reset
  // Control register operation codes
  localparam logic [2:0] CTRL_SIG_RANDOM = 3'h3;
  localparam logic [2:0] CTRL_SIG_COUNT = 3'h7;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Feedback polynomial, bit i set means stage i feeds back
  localparam logic [19:0] LFSR_TAPS = 20'h90000;
  // Host preamble lengths from Run-Test/Idle to the shift state, and the reset command length
  localparam logic [2:0] PRE_IR = 3'h4;
  localparam logic [2:0] PRE_DR = 3'h3;
  localparam logic [2:0] RESET_LEN = 3'h6;

  // Test access port states, gray codes along the scan paths
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h3, TAP_CAP_DR = 4'h2,
    TAP_SH_DR = 4'h6, TAP_EX1_DR = 4'h7, TAP_PAU_DR = 4'h5, TAP_EX2_DR = 4'h4,
    TAP_UPD_DR = 4'hc, TAP_SEL_IR = 4'hd, TAP_CAP_IR = 4'hf, TAP_SH_IR = 4'he,
    TAP_EX1_IR = 4'ha, TAP_PAU_IR = 4'hb, TAP_EX2_IR = 4'h9, TAP_UPD_IR = 4'h8
  } bst_tap_t;

  // Host commands
  typedef enum logic [1:0] {
    CMD_RESET = 2'h0, CMD_IR = 2'h1, CMD_DR = 2'h2, CMD_IDLE = 2'h3
  } bst_cmd_t;

  // One step of a 20-stage shift register with feedback and parallel fold-in
  function automatic logic [19:0] bst_lfsr(input logic [19:0] v, input logic [19:0] taps,
                                           input logic [19:0] fold);
    bst_lfsr = {v[18:0], ^(v & taps)} ^ fold;
  endfunction : bst_lfsr
endpackage : bst_pkg

// File: sim/bst_link_sva.sv
// Checker for the wire-level timing of the test access link
`timescale 1ns/10ps
`default_nettype none
module bst_link_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdoOut,
  input wire logic tdoOe,
  input wire logic tdo
);
  import bst_pkg::*;
  bst_tap_t tapState_ff;  // Port state as seen from the wires
  bst_tap_t nxt_tapState;
  logic [3:0] irBit_ff;  // Bits already shifted out in Shift-IR
  logic [3:0] nxt_irBit;
  logic inShift;  // Device should be driving serial out

  // Shadow port state machine, stepped by mode-select on each rising edge
  always_comb begin
    nxt_irBit = (tapState_ff == TAP_SH_IR) ? irBit_ff + 4'h1 : 4'h0;
    case (tapState_ff)
      TAP_RESET: nxt_tapState = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: nxt_tapState = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: nxt_tapState = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR, TAP_SH_DR: nxt_tapState = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: nxt_tapState = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: nxt_tapState = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: nxt_tapState = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_SEL_IR: nxt_tapState = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR, TAP_SH_IR: nxt_tapState = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: nxt_tapState = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: nxt_tapState = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: nxt_tapState = tms ? TAP_UPD_IR : TAP_SH_IR;
      default: nxt_tapState = tms ? TAP_SEL_DR : TAP_IDLE;  // Both update states
    endcase
  end

  // Register the shadow state; reset matches the device's own
  always_ff @(posedge tck or negedge rstn) begin
    if (!rstn) begin
      tapState_ff <= TAP_RESET;
      irBit_ff <= 4'h0;
    end else begin
      tapState_ff <= nxt_tapState;
      irBit_ff <= nxt_irBit;
    end
  end

  assign inShift = (tapState_ff == TAP_SH_IR) || (tapState_ff == TAP_SH_DR);

  // Test clock is 8 core cycles long, high for 4
  property p_tck_period;
    @(posedge core_clk) disable iff (!rstn) $rose(tck) |-> ##8 $rose(tck);
  endproperty
  a_tck_period: assert property (p_tck_period)
    else $error("test clock period wrong");
  property p_tck_high;
    @(posedge core_clk) disable iff (!rstn) $rose(tck) |-> tck [*4] ##1 !tck;
  endproperty
  a_tck_high: assert property (p_tck_high)
    else $error("test clock high phase wrong");
  // Host moves select and data only as it drives the clock low
  property p_tms_on_fall;
    @(posedge core_clk) disable iff (!rstn) $changed(tms) |-> $fell(tck);
  endproperty
  a_tms_on_fall: assert property (p_tms_on_fall)
    else $error("mode select moved off the falling edge");
  property p_tdi_on_fall;
    @(posedge core_clk) disable iff (!rstn) $changed(tdi) |-> $fell(tck);
  endproperty
  a_tdi_on_fall: assert property (p_tdi_on_fall)
    else $error("serial in moved off the falling edge");
  // Device outputs move only on the falling edge
  property p_tdo_on_fall;
    @(posedge core_clk) disable iff (!rstn) $changed(tdoOut) |-> $fell(tck);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall)
    else $error("serial out moved off the falling edge");
  property p_oe_on_fall;
    @(posedge core_clk) disable iff (!rstn) $changed(tdoOe) |-> $fell(tck);
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall)
    else $error("serial out enable moved off the falling edge");
  // Enable follows the state held at the last falling edge
  property p_oe_shift;
    @(posedge tck) disable iff (!rstn) tdoOe == inShift;
  endproperty
  a_oe_shift: assert property (p_oe_shift)
    else $error("serial out enable does not match shift state");
  // Captured instruction value leaves lsb first
  property p_ir_capture;
    @(posedge tck) disable iff (!rstn)
      (tapState_ff == TAP_SH_IR && irBit_ff < 4'h8) |-> tdoOut == IR_CAPTURE[irBit_ff[2:0]];
  endproperty
  a_ir_capture: assert property (p_ir_capture)
    else $error("captured instruction bit wrong");
  // A released serial line must read as the pulled-high level
  property p_tdo_released;
    @(posedge core_clk) disable iff (!rstn) !tdoOe |-> tdo;
  endproperty
  a_tdo_released: assert property (p_tdo_released)
    else $error("released serial line not high");
endmodule : bst_link_sva
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench joining host and device over the test access link
`timescale 1ns/10ps
`default_nettype none
module tb;
  import bst_pkg::*;
  logic core_clk = 1'b0;  // 40 MHz core clock
  logic rstn = 1'b1;  // Dropped just after time zero so every reset sees a real edge
  logic cmdValid = 1'b0;
  bst_cmd_t cmdKind = CMD_RESET;
  logic [LEN_W-1:0] cmdLen = 6'h00;
  logic [CHAIN_W-1:0] cmdData = 40'h0;
  logic cmdReady;
  logic rspValid;
  logic [CHAIN_W-1:0] rspData;
  logic [HALF_W-1:0] inPins = 20'h00000;  // Held steady during a run, so sync lag is moot
  logic [HALF_W-1:0] outPins;
  logic aToBOutputEnableN = 1'b0;  // A to B enabled
  logic bToAOutputEnableN = 1'b1;
  logic testActive;
  int errCount = 0;
  int nCompared = 0;
  logic [CHAIN_W-1:0] model;  // Expected chain contents
  logic stepOn = 1'b0;  // Legal mode, so the model follows the steps
  logic countMode = 1'b0;  // Output half counts instead of stepping
  logic sawActive = 1'b0;  // Any step seen since last cleared

  bst_link_if link ();
  bst_host i_bst_host (.core_clk(core_clk), .rstn(rstn), .link(link), .cmdValid(cmdValid),
    .cmdKind(cmdKind), .cmdLen(cmdLen), .cmdData(cmdData), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData));
  bst_device i_bst_device (.link(link), .rstn(rstn), .inPins(inPins),
    .aToBOutputEnableN(aToBOutputEnableN), .bToAOutputEnableN(bToAOutputEnableN),
    .outPins(outPins), .testActive(testActive));
  bst_link_sva i_bst_link_sva (.core_clk(core_clk), .rstn(rstn), .tck(link.tck),
    .tms(link.tms), .tdi(link.tdi), .tdoOut(link.tdoOut), .tdoOe(link.tdoOe), .tdo(link.tdo));

  always #12.5 core_clk = ~core_clk;

  // One pattern step with no fold-in
  function automatic logic [19:0] step_lfsr(input logic [19:0] v);
    step_lfsr = {v[18:0], ^(v & LFSR_TAPS)};
  endfunction : step_lfsr

  // Chain model; a step is due on each rise after a falling edge that showed activity
  always @(posedge link.tck) begin
    if (testActive === 1'b1) begin
      sawActive <= 1'b1;
    end
    if (stepOn && testActive === 1'b1) begin
      // Pins show the output half as it stood before this step
      check("pins during test", {20'h0, outPins}, {20'h0, model[39:20]});
      model[19:0] <= step_lfsr(model[19:0]) ^ inPins;
      model[39:20] <= countMode ? model[39:20] + 20'h00001 : step_lfsr(model[39:20]);
    end
  end

  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // Issue one command and wait for its answer; a hang ends the run
  task automatic run_cmd(input bst_cmd_t kind, input logic [5:0] len, input logic [39:0] data);
    int n;
    n = 0;
    @(negedge core_clk);
    while (cmdReady !== 1'b1 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
    cmdKind = kind;
    cmdLen = len;
    cmdData = data;
    cmdValid = 1'b1;
    @(negedge core_clk);
    cmdValid = 1'b0;
    while (rspValid !== 1'b1 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 2000) begin
      errCount++;
      tally_and_finish();
    end
  endtask : run_cmd

  // Main sequence: scans first, then each self-test mode and its corner cases
  initial begin
    logic [39:0] seed;
    logic [2:0] code;
    void'($urandom(32'hc0452985));
    #1 rstn = 1'b0;
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    run_cmd(CMD_RESET, 6'h00, 40'h0);
    run_cmd(CMD_IR, 6'h08, 40'hff);
    check("ir capture", rspData, 40'h81);
    run_cmd(CMD_DR, 6'h03, 40'h5);
    check("bypass scan", rspData, 40'h2);
    // Cases: random, count, unused code, equal enables, zero pattern seed
    for (int k = 0; k < 5; k++) begin
      code = (k == 0 || k == 4) ? CTRL_SIG_RANDOM : ((k == 2) ? 3'h1 : CTRL_SIG_COUNT);
      bToAOutputEnableN = (k != 3);  // Equal enables in case 3
      inPins = 20'($urandom);
      seed = {20'($urandom), 20'($urandom)};
      if (k == 4) begin
        seed[39:20] = 20'h00000;
      end
      run_cmd(CMD_IR, 6'h08, {32'h0, OP_CTRL_SCAN});
      run_cmd(CMD_DR, 6'h03, {37'h0, code});
      run_cmd(CMD_IR, 6'h08, {32'h0, OP_CHAIN});
      run_cmd(CMD_DR, 6'h28, seed);
      check("seed on pins", {20'h0, outPins}, {20'h0, seed[39:20]});
      model = seed;
      countMode = (code == CTRL_SIG_COUNT);
      stepOn = (k != 2 && k != 3);
      sawActive = 1'b0;
      run_cmd(CMD_IR, 6'h08, {32'h0, OP_RUN_SELECTED_TEST});
      run_cmd(CMD_IDLE, 6'(5 + $urandom_range(20)), 40'h0);
      run_cmd(CMD_IR, 6'h08, {32'h0, OP_CHAIN});
      check("test active", {39'h0, sawActive}, {39'h0, stepOn});
      run_cmd(CMD_DR, 6'h28, 40'h0);
      check("chain after test", rspData, model);
      stepOn = 1'b0;
    end
    tally_and_finish();
  end

  // Watchdog, far beyond the roughly 7500 cycles the sequence needs
  initial begin
    #1000000;
    errCount++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
